// ---- shared/ivm_regs.vh ----
/*
 Register offsets, field positions, reset values and fixed vector figures
 for the interrupt vector map block. Assumes APB byte addressing with one
 aligned 32-bit word per register.
*/
`ifndef IVM_REGS_VH
`define IVM_REGS_VH

`define IVM_NUM_CH 32
`define IVM_NUM_CORE_EXC 16
`define IVM_NUM_LINES 28
`define IVM_PRIO_W 2

// Register byte offsets
`define IVM_OFF_CH_EN 12'h000
`define IVM_OFF_CH_PEND 12'h004
`define IVM_OFF_PRIO_LO 12'h008
`define IVM_OFF_PRIO_HI 12'h00C
`define IVM_OFF_SVC_PRIO 12'h010
`define IVM_OFF_LINE_MASK 12'h014
`define IVM_OFF_LINE_MODE 12'h018
`define IVM_OFF_LINE_PEND 12'h01C
`define IVM_OFF_VECTOR 12'h020
`define IVM_OFF_STATUS 12'h024

// Reset values
`define IVM_RST_CH_EN 32'h0000_0000
`define IVM_RST_PRIO 32'h0000_0000
`define IVM_RST_SVC_PRIO 2'h0
`define IVM_RST_LINES 28'h000_0000

// Status register fields
`define IVM_STAT_VALID 0
`define IVM_STAT_SVC 1

// Vector figures
`define IVM_VEC_BASE 32'h0000_0040
`define IVM_VEC_SVC 32'h0000_002C

// Merged channel numbers
`define IVM_CH_LINE0_1 5
`define IVM_CH_LINE2_3 6
`define IVM_CH_LINE4_15 7
`define IVM_CH_DMA2_3 10
`define IVM_CH_DMA4_5 11
`define IVM_CH_ADC_CMP 12
`define IVM_CH_TIMER_ONE 13
`define IVM_CH_TIMER_SIX 17

`endif

// ---- core/ivm_prio_arb.v ----
/*
 Priority arbiter: picks the pending request with the lowest priority value,
 lowest index on a tie. Purely combinational; the caller registers results.
*/
`timescale 1ns/1ps
`default_nettype none

module ivm_prio_arb #(
	parameter N = 32,
	parameter IW = 5,
	parameter PW = 2
) (
	input wire [N-1:0] req,
	input wire [N*PW-1:0] prio,
	output reg found,
	output reg [IW-1:0] idx,
	output reg [PW-1:0] level
);

	integer i;

	always @*
	begin
		found = 1'b0;
		idx = {IW{1'b0}};
		level = {PW{1'b1}};
		// Strictly lower value wins, so earlier index keeps ties
		for (i = 0; i < N; i = i + 1)
		begin
			if (req[i] && (!found || prio[i*PW +: PW] < level))
			begin
				found = 1'b1;
				idx = i[IW-1:0];
				level = prio[i*PW +: PW];
			end
		end
	end

endmodule

`default_nettype wire

// ---- core/ivm_top.v ----
/*
 Interrupt vector map: merges peripheral requests and external lines 0 to 15
 onto 32 maskable channels, arbitrates by 2-bit priority with the supervisor
 call, and presents one vectored request to the processor core. Holds the
 external line unit front end: masking, mode, pending bits, event pulses.
 Assumes all inputs are synchronous to pclk and registers reached by APB.
*/
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ivm_regs.vh"

module ivm_top #(
	parameter NUM_CH = `IVM_NUM_CH,
	parameter NUM_LINES = `IVM_NUM_LINES,
	parameter [NUM_LINES-1:0] INTERNAL_LINES = 28'hFFC_0000
) (
	input wire pclk,
	input wire presetn,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata_q,
	output reg pready_q,
	output reg pslverr_q,
	input wire [NUM_CH-1:0] periph_irq,
	input wire [NUM_LINES-1:0] line_in,
	input wire stop_mode,
	input wire dma_ch2_irq,
	input wire dma_ch3_irq,
	input wire dma_ch4_irq,
	input wire dma_ch5_irq,
	input wire adc_irq,
	input wire cmp_irq,
	input wire timer_break_irq,
	input wire timer_overflow_irq,
	input wire timer_trigger_irq,
	input wire timer_phase_switch_irq,
	input wire basic_timer_six_irq,
	input wire dac_underrun_irq,
	input wire svc_req,
	input wire irq_ack,
	output reg irq_valid_q,
	output reg irq_is_svc_q,
	output reg [31:0] irq_vector_q,
	output reg [`IVM_PRIO_W-1:0] irq_prio_q,
	output reg [4:0] irq_channel_q,
	output reg [NUM_LINES-1:0] event_pulse_q
);

	reg [NUM_CH-1:0] ch_en_q;
	reg [31:0] prio_lo_q;
	reg [31:0] prio_hi_q;
	reg [`IVM_PRIO_W-1:0] svc_prio_q;
	reg [NUM_LINES-1:0] line_mask_q;
	reg [NUM_LINES-1:0] line_mode_q;
	reg [NUM_LINES-1:0] line_pend_q;
	reg [NUM_LINES-1:0] line_pend_d;
	reg [NUM_LINES-1:0] line_prev_q;
	reg svc_pend_q;
	reg svc_pend_d;
	reg [NUM_CH-1:0] ch_raw;
	reg [31:0] rdata_d;
	reg addr_ok;

	wire [NUM_CH-1:0] ch_pend;
	wire [NUM_LINES-1:0] line_live;
	wire [NUM_LINES-1:0] line_rise;
	wire apb_setup_done;
	wire apb_commit;
	wire wr_commit;
	wire arb_found;
	wire [4:0] arb_idx;
	wire [`IVM_PRIO_W-1:0] arb_level;
	wire svc_wins;
	wire [11:0] offs;

	assign offs = paddr[11:0];
	// First access cycle: read data captured, ready raised for the next edge
	assign apb_setup_done = psel & penable & ~pready_q;
	// Transfer completes on the edge where ready is seen high
	assign apb_commit = psel & penable & pready_q;
	assign wr_commit = apb_commit & pwrite & addr_ok;

	// Internal lines are held off unless the system sits in stop mode
	assign line_live = line_mask_q & ~(INTERNAL_LINES & {NUM_LINES{~stop_mode}});
	assign line_rise = line_in & ~line_prev_q & line_live;

	// Interrupt-mode lines latch pending; writing one clears it, a new edge wins
	always @*
	begin
		line_pend_d = line_pend_q;
		if (wr_commit && offs == `IVM_OFF_LINE_PEND)
		begin
			line_pend_d = line_pend_q & ~pwdata[NUM_LINES-1:0];
		end
		line_pend_d = line_pend_d | (line_rise & ~line_mode_q);
	end

	// Source merging onto the shared channels
	always @*
	begin
		ch_raw = periph_irq;
		ch_raw[`IVM_CH_LINE0_1] = |line_pend_q[1:0];
		ch_raw[`IVM_CH_LINE2_3] = |line_pend_q[3:2];
		ch_raw[`IVM_CH_LINE4_15] = |line_pend_q[15:4];
		ch_raw[`IVM_CH_DMA2_3] = dma_ch2_irq | dma_ch3_irq;
		ch_raw[`IVM_CH_DMA4_5] = dma_ch4_irq | dma_ch5_irq;
		ch_raw[`IVM_CH_ADC_CMP] = adc_irq | cmp_irq;
		ch_raw[`IVM_CH_TIMER_ONE] = timer_break_irq | timer_overflow_irq |
			timer_trigger_irq | timer_phase_switch_irq;
		ch_raw[`IVM_CH_TIMER_SIX] = basic_timer_six_irq | dac_underrun_irq;
	end

	assign ch_pend = ch_raw & ch_en_q;

	ivm_prio_arb #(
		.N(NUM_CH),
		.IW(5),
		.PW(`IVM_PRIO_W)
	) u_arb (
		.req(ch_pend),
		.prio({prio_hi_q, prio_lo_q}),
		.found(arb_found),
		.idx(arb_idx),
		.level(arb_level)
	);

	// Supervisor call takes ties, being a core exception below the channels
	assign svc_wins = svc_pend_q & (~arb_found | (svc_prio_q <= arb_level));

	// New call wins over an acknowledge in the same cycle
	always @*
	begin
		svc_pend_d = svc_pend_q;
		if (irq_ack && irq_valid_q && irq_is_svc_q)
		begin
			svc_pend_d = 1'b0;
		end
		if (svc_req)
		begin
			svc_pend_d = 1'b1;
		end
	end

	// Register decode and read mux
	always @*
	begin
		addr_ok = 1'b1;
		rdata_d = 32'h0000_0000;
		case (offs)
			`IVM_OFF_CH_EN:
			begin
				rdata_d = ch_en_q;
			end
			`IVM_OFF_CH_PEND:
			begin
				rdata_d = ch_pend;
			end
			`IVM_OFF_PRIO_LO:
			begin
				rdata_d = prio_lo_q;
			end
			`IVM_OFF_PRIO_HI:
			begin
				rdata_d = prio_hi_q;
			end
			`IVM_OFF_SVC_PRIO:
			begin
				rdata_d = {30'h0000_0000, svc_prio_q};
			end
			`IVM_OFF_LINE_MASK:
			begin
				rdata_d = {4'h0, line_mask_q};
			end
			`IVM_OFF_LINE_MODE:
			begin
				rdata_d = {4'h0, line_mode_q};
			end
			`IVM_OFF_LINE_PEND:
			begin
				rdata_d = {4'h0, line_pend_q};
			end
			`IVM_OFF_VECTOR:
			begin
				rdata_d = irq_vector_q;
			end
			`IVM_OFF_STATUS:
			begin
				rdata_d = {30'h0000_0000, svc_pend_q, irq_valid_q};
			end
			default:
			begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// APB slave handshake
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end
		else if (clk_en)
		begin
			pready_q <= apb_setup_done;
			pslverr_q <= apb_setup_done & ~addr_ok;
			if (apb_setup_done && !pwrite)
			begin
				prdata_q <= rdata_d;
			end
			else if (apb_commit)
			begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// Software-written control registers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ch_en_q <= `IVM_RST_CH_EN;
			prio_lo_q <= `IVM_RST_PRIO;
			prio_hi_q <= `IVM_RST_PRIO;
			svc_prio_q <= `IVM_RST_SVC_PRIO;
			line_mask_q <= `IVM_RST_LINES;
			line_mode_q <= `IVM_RST_LINES;
		end
		else if (clk_en && wr_commit)
		begin
			case (offs)
				`IVM_OFF_CH_EN:
				begin
					ch_en_q <= pwdata[NUM_CH-1:0];
				end
				`IVM_OFF_PRIO_LO:
				begin
					prio_lo_q <= pwdata;
				end
				`IVM_OFF_PRIO_HI:
				begin
					prio_hi_q <= pwdata;
				end
				`IVM_OFF_SVC_PRIO:
				begin
					svc_prio_q <= pwdata[`IVM_PRIO_W-1:0];
				end
				`IVM_OFF_LINE_MASK:
				begin
					line_mask_q <= pwdata[NUM_LINES-1:0];
				end
				`IVM_OFF_LINE_MODE:
				begin
					line_mode_q <= pwdata[NUM_LINES-1:0];
				end
				default:
				begin
					ch_en_q <= ch_en_q;
				end
			endcase
		end
	end

	// Line unit state, event pulses and supervisor call pending
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			line_prev_q <= `IVM_RST_LINES;
			line_pend_q <= `IVM_RST_LINES;
			event_pulse_q <= `IVM_RST_LINES;
			svc_pend_q <= 1'b0;
		end
		else if (clk_en)
		begin
			line_prev_q <= line_in;
			line_pend_q <= line_pend_d;
			event_pulse_q <= line_rise & line_mode_q;
			svc_pend_q <= svc_pend_d;
		end
	end

	// Winning request toward the processor core
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_valid_q <= 1'b0;
			irq_is_svc_q <= 1'b0;
			irq_vector_q <= 32'h0000_0000;
			irq_prio_q <= {`IVM_PRIO_W{1'b0}};
			irq_channel_q <= 5'h00;
		end
		else if (clk_en)
		begin
			irq_valid_q <= arb_found | svc_wins;
			irq_is_svc_q <= svc_wins;
			if (svc_wins)
			begin
				irq_vector_q <= `IVM_VEC_SVC;
				irq_prio_q <= svc_prio_q;
				irq_channel_q <= 5'h00;
			end
			else if (arb_found)
			begin
				irq_vector_q <= `IVM_VEC_BASE + {25'h000_0000, arb_idx, 2'b00};
				irq_prio_q <= arb_level;
				irq_channel_q <= arb_idx;
			end
			else
			begin
				irq_vector_q <= 32'h0000_0000;
				irq_prio_q <= {`IVM_PRIO_W{1'b0}};
				irq_channel_q <= 5'h00;
			end
		end
	end

endmodule

`default_nettype wire

// ---- tb/ivm_core_model.sv ----
/*
 Processor core stand-in: acknowledges a presented supervisor call.
 Assumes pclk domain, ack one cycle after ack_delay cycles of waiting.
*/
`timescale 1ns/1ps
`default_nettype none
module ivm_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] ack_delay,
	input wire logic irq_valid_q,
	input wire logic irq_is_svc_q,
	output logic irq_ack
);
	logic [3:0] cnt_q;
	logic busy_q;
	// One ack per presented call, then wait for it to leave
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_q <= 4'h0;
			busy_q <= 1'b0;
			irq_ack <= 1'b0;
		end
		else
		begin
			irq_ack <= 1'b0;
			if (!irq_is_svc_q)
				busy_q <= 1'b0;
			if (irq_valid_q && irq_is_svc_q && !busy_q)
			begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q >= ack_delay)
				begin
					irq_ack <= 1'b1;
					busy_q <= 1'b1;
					cnt_q <= 4'h0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- tb/ivm_top_properties.sv ----
/*
 Port checker for ivm_top, bound into it.
 Assumes one clock, pclk, and clk_en low only while the bus is idle.
*/
`timescale 1ns/1ps
`default_nettype none
module ivm_top_properties #(
	parameter NUM_LINES = 28,
	parameter [NUM_LINES-1:0] INTERNAL_LINES = 28'hFFC_0000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready_q,
	input wire logic pslverr_q,
	input wire logic [NUM_LINES-1:0] line_in,
	input wire logic stop_mode,
	input wire logic irq_valid_q,
	input wire logic irq_is_svc_q,
	input wire logic [31:0] irq_vector_q,
	input wire logic [1:0] irq_prio_q,
	input wire logic [4:0] irq_channel_q,
	input wire logic [NUM_LINES-1:0] event_pulse_q
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_svc_vector: assert property (
		irq_is_svc_q |-> irq_valid_q && irq_vector_q == 32'h0000_002C && irq_channel_q == 5'h00)
		else $error("supervisor call vector wrong");
	a_chan_vector: assert property (
		irq_valid_q && !irq_is_svc_q |-> irq_vector_q == 32'h0000_0040 + {irq_channel_q, 2'b00})
		else $error("channel vector wrong");
	a_idle_zero: assert property (
		!irq_valid_q |-> irq_vector_q == 32'h0000_0000 && irq_prio_q == 2'h0 && irq_channel_q == 5'h00)
		else $error("idle request outputs not zero");
	a_event_edge: assert property (
		(event_pulse_q & ~($past(line_in) & ~$past(line_in, 2))) == '0)
		else $error("event pulse without rising edge");
	a_internal_off: assert property (
		!$past(stop_mode) |-> (event_pulse_q & INTERNAL_LINES) == '0)
		else $error("internal line active outside stop mode");
	a_ready_pulse: assert property (pready_q |=> !pready_q)
		else $error("pready longer than one cycle");
	a_ready_after: assert property (psel && penable && !pready_q && clk_en |=> pready_q)
		else $error("pready late");
	a_err_ready: assert property (pslverr_q |-> pready_q)
		else $error("pslverr without pready");
endmodule
bind ivm_top ivm_top_properties #(.NUM_LINES(NUM_LINES), .INTERNAL_LINES(INTERNAL_LINES)) u_props (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
	.pready_q(pready_q), .pslverr_q(pslverr_q), .line_in(line_in), .stop_mode(stop_mode),
	.irq_valid_q(irq_valid_q), .irq_is_svc_q(irq_is_svc_q), .irq_vector_q(irq_vector_q),
	.irq_prio_q(irq_prio_q), .irq_channel_q(irq_channel_q), .event_pulse_q(event_pulse_q));
`default_nettype wire

// ---- tb/testbench.sv ----
/*
 Self-checking bench for ivm_top over APB.
 Assumes ivm_regs.vh on the include path and the core model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ivm_regs.vh"
module testbench;
	logic pclk, presetn, psel, penable, pwrite, stop_mode, svc_req, irq_ack, irq_valid_q, irq_is_svc_q;
	logic pready_q, pslverr_q, e, clk_en;
	logic [31:0] paddr, pwdata, prdata_q, periph_irq, irq_vector_q, r, x;
	logic [27:0] line_in, event_pulse_q;
	logic [11:0] src;
	logic [1:0] irq_prio_q;
	logic [4:0] irq_channel_q;
	logic [3:0] ack_delay;
	int mismatches, tests_run, i, j;
	int exp_ch[12] = '{10, 10, 11, 11, 12, 12, 13, 13, 13, 13, 17, 17};
	int lines[6] = '{0, 1, 2, 3, 4, 15};
	ivm_top dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
		.pslverr_q(pslverr_q), .periph_irq(periph_irq), .line_in(line_in), .stop_mode(stop_mode),
		.dma_ch2_irq(src[0]), .dma_ch3_irq(src[1]), .dma_ch4_irq(src[2]), .dma_ch5_irq(src[3]),
		.adc_irq(src[4]), .cmp_irq(src[5]), .timer_break_irq(src[6]), .timer_overflow_irq(src[7]),
		.timer_trigger_irq(src[8]), .timer_phase_switch_irq(src[9]), .basic_timer_six_irq(src[10]),
		.dac_underrun_irq(src[11]), .svc_req(svc_req), .irq_ack(irq_ack), .irq_valid_q(irq_valid_q),
		.irq_is_svc_q(irq_is_svc_q), .irq_vector_q(irq_vector_q), .irq_prio_q(irq_prio_q),
		.irq_channel_q(irq_channel_q), .event_pulse_q(event_pulse_q));
	ivm_core_model core (.pclk(pclk), .presetn(presetn), .ack_delay(ack_delay),
		.irq_valid_q(irq_valid_q), .irq_is_svc_q(irq_is_svc_q), .irq_ack(irq_ack));
	task test_done;
		$display("compared %0d, wrong %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] w);
		tests_run++;
		if (g !== w)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, g, w);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {20'h0_0000, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for ready
		do
		begin
			@(posedge pclk);
		end
		while (pready_q !== 1'b1);
		r = prdata_q;
		e = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task tick(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	initial
	begin
		#400000;
		mismatches++;
		test_done;
	end
	initial
	begin
		{presetn, psel, penable, pwrite, stop_mode, svc_req} = 6'h00;
		clk_en = 1'b1;
		paddr = 32'h0; pwdata = 32'h0; periph_irq = 32'h0; line_in = 28'h0; src = 12'h000; ack_delay = 4'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `IVM_OFF_CH_EN, 0); chk(r, `IVM_RST_CH_EN);
		apb(0, `IVM_OFF_PRIO_LO, 0); chk(r, `IVM_RST_PRIO);
		apb(0, `IVM_OFF_LINE_MODE, 0); chk(r, 32'h0);
		apb(0, 12'h100, 0); chk({r[30:0], e}, 32'h1);
		apb(1, `IVM_OFF_CH_EN, 32'hFFFF_FFFF);
		apb(1, `IVM_OFF_LINE_MASK, 32'h0FFF_FFFF);
		$display("test reset done");
		for (i = 0; i < 12; i++)
		begin
			@(posedge pclk); src <= 12'h001 << i; tick(2);
			x = 32'h40 + 4 * exp_ch[i];
			chk(irq_vector_q, x);
			@(posedge pclk); src <= 12'h000; tick(2);
		end
		$display("test merges done");
		for (i = 0; i < 6; i++)
		begin
			j = lines[i];
			@(posedge pclk); line_in <= 28'h1 << j; tick(2);
			x = j < 2 ? 32'h54 : j < 4 ? 32'h58 : 32'h5C;
			chk(irq_vector_q, x);
			apb(0, `IVM_OFF_LINE_PEND, 0); chk(r, 32'h1 << j);
			apb(1, `IVM_OFF_LINE_PEND, 32'h1 << j);
			@(posedge pclk); line_in <= 28'h0; tick(2);
			chk(irq_valid_q, 1'b0);
		end
		apb(1, `IVM_OFF_LINE_MASK, 32'h0FFF_FFFB);
		@(posedge pclk); line_in <= 28'hC; tick(2);
		apb(0, `IVM_OFF_LINE_PEND, 0); chk(r, 32'h8);
		apb(1, `IVM_OFF_LINE_PEND, 32'h8);
		apb(1, `IVM_OFF_LINE_MODE, 32'h0010_0010);
		@(posedge pclk); line_in <= 28'h010_0010; tick(1);
		chk(event_pulse_q, 28'h000_0010);
		tick(1); chk(irq_valid_q, 1'b0);
		@(posedge pclk); line_in <= 28'h0; stop_mode <= 1'b1;
		@(posedge pclk); line_in <= 28'h010_0010; tick(1);
		chk(event_pulse_q, 28'h010_0010);
		$display("test lines done");
		apb(1, `IVM_OFF_PRIO_LO, 32'h7);
		apb(1, `IVM_OFF_SVC_PRIO, 32'h1);
		@(posedge pclk); periph_irq <= 32'h3; tick(2);
		chk({irq_prio_q, irq_vector_q[7:0]}, 10'h144);
		for (i = 0; i < 2; i++)
		begin
			@(posedge pclk); ack_delay <= 4'h5 * i; svc_req <= 1'b1;
			@(posedge pclk); svc_req <= 1'b0; tick(1);
			chk({irq_is_svc_q, irq_vector_q[30:0]}, 32'h8000_002C);
			j = 0;
			while (irq_is_svc_q !== 1'b0 && j < 20)
			begin
				tick(1);
				j++;
			end
			chk(irq_is_svc_q, 1'b0);
			tick(1);
			chk(irq_vector_q, 32'h44);
		end
		// Frozen clock enable must hold the presented channel
		@(posedge pclk); clk_en <= 1'b0; periph_irq <= 32'h8000_0000; tick(3);
		chk(irq_channel_q, 5'd1);
		@(posedge pclk); clk_en <= 1'b1; tick(2);
		chk(irq_channel_q, 5'd31);
		$display("test priority done");
		test_done;
	end
endmodule
`default_nettype wire
